// [hdl/pcg_top.sv]
// Programmable CRC generator: registers, word counting and serial shifter
// Function
// - Taps for powers one to fifteen, length from a four-bit field.
// - Constant term always fed back; top term implied by the length field.
// - Shifting begins only after software writes shift_go as one.
// - FIFO depth is 8 when length field exceeds 7, else 16.
// - Data port takes byte writes as its smallest unit.
// - Count rises when the byte holding the word's top bit arrives.
// - Shifter runs while shift_go set and count nonzero, until zero.
// - Count falls once per word fully shifted into the engine.
// - Each word takes length field plus one cycles.
// - Full flag set when count equals current depth.
// - Empty flag set when count is zero.
// - A word write while full rolls count to zero, no interrupt.
// - Interrupt pulses when count goes from one to zero.
// - Length field holds polynomial length minus one.
// - Clearing shift_go stops the shifter only after FIFO empties.
// - With idle_stop_bit set, operation halts in Idle mode.
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "pcg_cfg.svh"
module pcg_top import pcg_pkg::*; (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic i_idle_mode,
    input wire logic [`PCG_ADDR_W-1:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic [1:0] i_byte_en,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    output logic o_irq,
    output logic o_fifo_full_flag,
    output logic o_fifo_empty_flag
);
    // ==========================================
    // State
    logic idle_stop_bit_q;
    logic shift_go_q;
    logic [3:0] poly_length_minus_one_q;
    logic [15:1] polynomial_tap_register_q;
    logic [7:0] low_byte_q;
    pcg_count_t valid_word_count_q;
    pcg_count_t valid_word_count_d;
    logic [3:0] bit_cnt_q;
    pcg_shift_t shift_st_q;
    logic [15:0] rdata_q;
    logic irq_q;
    logic full_q;
    logic empty_q;

    // ==========================================
    // Register decode
    logic wr_ctrl;
    logic wr_tap;
    logic wr_data;
    logic [3:0] plen_d;
    logic long_word;
    assign wr_ctrl = i_clk_en && i_wr && (i_addr == `PCG_ADDR_CTRL);
    assign wr_tap = i_clk_en && i_wr && (i_addr == `PCG_ADDR_TAP);
    assign wr_data = i_clk_en && i_wr && (i_addr == `PCG_ADDR_DATA);
    assign plen_d = (wr_ctrl && i_byte_en[0]) ?
        i_wdata[`PCG_CTRL_PLEN_LSB +: 4] : poly_length_minus_one_q;
    assign long_word = poly_length_minus_one_q > `PCG_PLEN_SPLIT;

    // ==========================================
    // Word assembly from byte writes
    logic word_done;
    pcg_word_t push_word;
    // Top bit sits in the high byte only for lengths above eight
    assign word_done = wr_data && (long_word ? i_byte_en[1] : i_byte_en[0]);
    assign push_word = long_word ?
        {i_wdata[15:8], (i_byte_en[0] ? i_wdata[7:0] : low_byte_q)} :
        {8'h00, i_wdata[7:0]};

    // ==========================================
    // Depth, flags and counting
    pcg_count_t depth;
    pcg_count_t depth_d;
    logic full;
    logic empty;
    logic flush;
    logic run_en;
    logic running;
    logic shift_en;
    logic pop;
    logic fall_event;
    assign depth = long_word ? `PCG_DEPTH_LONG : `PCG_DEPTH_SHORT;
    assign depth_d = (plen_d > `PCG_PLEN_SPLIT) ? `PCG_DEPTH_LONG : `PCG_DEPTH_SHORT;
    assign full = valid_word_count_q == depth;
    assign empty = valid_word_count_q == 5'h00;
    // A word written while full throws the whole queue away
    assign flush = word_done && full;
    assign run_en = i_clk_en && !(idle_stop_bit_q && i_idle_mode);
    assign running = shift_go_q || (shift_st_q == SH_RUN);
    assign shift_en = run_en && running && !empty;
    assign pop = shift_en && (bit_cnt_q == poly_length_minus_one_q);
    assign valid_word_count_d = flush ? 5'h00 :
        5'(valid_word_count_q + {4'h0, word_done} - {4'h0, pop});
    assign fall_event = (valid_word_count_q == 5'h01) &&
        (valid_word_count_d == 5'h00) && !flush;

    // ==========================================
    // Store and engine
    pcg_word_t head;
    pcg_word_t rem;
    logic shift_bit;
    logic [3:0] bit_index;
    // Changing the length mid-word scrambles that word
    assign bit_index = 4'(poly_length_minus_one_q - bit_cnt_q);
    assign shift_bit = head[bit_index];

    pcg_fifo u_fifo (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_push(word_done),
        .i_pop(pop),
        .i_flush(flush),
        .i_wdata(push_word),
        .o_head(head)
    );

    pcg_engine u_engine (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_shift(shift_en),
        .i_clear(wr_tap),
        .i_bit(shift_bit),
        .i_plen(poly_length_minus_one_q),
        .i_taps(polynomial_tap_register_q),
        .o_rem(rem)
    );

    // ==========================================
    // Read mux
    logic [15:0] ctrl_view;
    logic [15:0] rd_mux;
    logic [15:0] rem_mask;
    assign ctrl_view = {2'b00, idle_stop_bit_q, valid_word_count_q, full, empty,
        1'b0, shift_go_q, poly_length_minus_one_q};
    assign rem_mask = 16'(17'h0_0002 << poly_length_minus_one_q) - 16'h0001;
    assign rd_mux = (i_addr == `PCG_ADDR_CTRL) ? ctrl_view :
        (i_addr == `PCG_ADDR_TAP) ? {polynomial_tap_register_q, 1'b0} :
        (i_addr == `PCG_ADDR_DATA) ? (rem & rem_mask) : 16'h0000;

    // ==========================================
    // Software registers
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            idle_stop_bit_q <= 1'b0;
            shift_go_q <= 1'b0;
            poly_length_minus_one_q <= `PCG_PLEN_RST;
            polynomial_tap_register_q <= `PCG_TAP_RST;
        end else begin
            if (wr_ctrl && i_byte_en[1]) idle_stop_bit_q <= i_wdata[`PCG_CTRL_IDLE];
            if (wr_ctrl && i_byte_en[0]) shift_go_q <= i_wdata[`PCG_CTRL_GO];
            poly_length_minus_one_q <= plen_d;
            if (wr_tap && i_byte_en[1]) polynomial_tap_register_q[15:8] <= i_wdata[15:8];
            if (wr_tap && i_byte_en[0]) polynomial_tap_register_q[7:1] <= i_wdata[7:1];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) low_byte_q <= 8'h00;
        else if (wr_data && long_word && i_byte_en[0] && !i_byte_en[1]) low_byte_q <= i_wdata[7:0];
    end

    // ==========================================
    // Counter, shifter state and bit position
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) valid_word_count_q <= 5'h00;
        else if (i_clk_en) valid_word_count_q <= valid_word_count_d;
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shift_st_q <= SH_OFF;
        end else if (run_en) begin
            unique case (shift_st_q)
                SH_OFF: if (shift_go_q) shift_st_q <= SH_RUN;
                SH_RUN: if (!shift_go_q && empty) shift_st_q <= SH_OFF;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) bit_cnt_q <= 4'h0;
        else if (flush) bit_cnt_q <= 4'h0;
        else if (pop) bit_cnt_q <= 4'h0;
        else if (shift_en) bit_cnt_q <= bit_cnt_q + 4'h1;
    end

    // ==========================================
    // Output flops
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_q <= 16'h0000;
            irq_q <= 1'b0;
            full_q <= 1'b0;
            empty_q <= 1'b1;
        end else if (i_clk_en) begin
            rdata_q <= i_rd ? rd_mux : 16'h0000;
            irq_q <= fall_event;
            full_q <= valid_word_count_d == depth_d;
            empty_q <= valid_word_count_d == 5'h00;
        end
    end

    assign o_rdata = rdata_q;
    assign o_irq = irq_q;
    assign o_fifo_full_flag = full_q;
    assign o_fifo_empty_flag = empty_q;

    // ==========================================
    // Checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_word_on_full;
        i_clk_en && word_done && full;
    endsequence

    full_flag_a: assert property (o_fifo_full_flag == (valid_word_count_q == depth))
        else $error("full flag disagrees with count");
    empty_flag_a: assert property (o_fifo_empty_flag == empty)
        else $error("empty flag disagrees with count");
    rollover_cnt_a: assert property (s_word_on_full |=> valid_word_count_q == 5'h00 && !o_irq)
        else $error("write on full did not roll over quietly");
    irq_cause_a: assert property (i_clk_en && valid_word_count_q == 5'h01 && pop && !word_done
        |=> o_irq && valid_word_count_q == 5'h00)
        else $error("missing interrupt on last word");
    count_inc_a: assert property (i_clk_en && word_done && !full && !pop
        |=> valid_word_count_q == $past(valid_word_count_q) + 5'h01)
        else $error("word write did not add one");
    go_gate_a: assert property (!shift_go_q && shift_st_q == SH_OFF |-> !shift_en)
        else $error("shifting without shift_go");
    word_time_a: assert property (shift_en && !pop && !flush
        |=> bit_cnt_q == $past(bit_cnt_q) + 4'h1)
        else $error("word not length plus one cycles");
    drain_run_a: assert property (shift_st_q == SH_RUN && !empty && run_en |-> shift_en)
        else $error("shifter stalled with words queued");
    idle_halt_a: assert property (idle_stop_bit_q && i_idle_mode |-> !shift_en
        ##1 ($stable(valid_word_count_q) || $past(word_done)))
        else $error("shifter ran in idle with stop set");
    depth_sel_a: assert property (full |-> valid_word_count_q ==
        (poly_length_minus_one_q > 4'h7 ? 5'h08 : 5'h10))
        else $error("wrong FIFO depth");

    // ==========================================
    // Checks on shifter control

    sequence s_go_write;
        wr_ctrl && i_byte_en[0] && i_wdata[`PCG_CTRL_GO];
    endsequence

    sequence s_run_no_go;
        shift_st_q == SH_RUN && !shift_go_q && run_en;
    endsequence

    go_start_a: assert property (s_go_write ##1 (run_en && !empty) |-> shift_en)
        else $error("shift_go write did not start the shifter");
    count_dec_a: assert property (i_clk_en && pop && !word_done
        |=> valid_word_count_q == $past(valid_word_count_q) - 5'h01)
        else $error("finished word did not remove one");
    word_end_a: assert property (pop && !flush |=> bit_cnt_q == 4'h0)
        else $error("bit position not restarted after word");
    run_hold_a: assert property (s_run_no_go ##0 !empty |=> shift_st_q == SH_RUN)
        else $error("shifter stopped with words queued");
    run_stop_a: assert property (s_run_no_go ##0 empty |=> shift_st_q == SH_OFF)
        else $error("shifter kept running after drain");
    idle_run_a: assert property (!idle_stop_bit_q && shift_go_q && !empty && i_clk_en
        |-> shift_en)
        else $error("shifter halted with idle stop clear");

    // ==========================================
    // Checks on count, data and outputs

    irq_only_fall_a: assert property (o_irq && $past(i_clk_en)
        |-> $past(valid_word_count_q) == 5'h01 && valid_word_count_q == 5'h00)
        else $error("interrupt without a one to zero step");
    roll_flags_a: assert property (s_word_on_full
        |=> o_fifo_empty_flag && !o_fifo_full_flag)
        else $error("flags wrong after rollover");
    byte_hold_a: assert property (wr_data && !word_done
        |=> valid_word_count_q <= $past(valid_word_count_q))
        else $error("partial word counted");
    const_term_a: assert property (shift_en && !wr_tap
        |=> rem[0] == $past(shift_bit ^ rem[poly_length_minus_one_q]))
        else $error("constant term missing from feedback");
    rem_clear_a: assert property (wr_tap |=> rem == 16'h0000)
        else $error("tap write did not seed the remainder");
    rem_hold_a: assert property (!shift_en && !wr_tap |=> $stable(rem))
        else $error("remainder moved without a shift");
    rdata_idle_a: assert property ($past(i_clk_en) && !$past(i_rd) |-> o_rdata == 16'h0000)
        else $error("read data outside the read cycle");
    // Clock enable low must freeze every piece of state
    freeze_hold_a: assert property (!i_clk_en |=> $stable(valid_word_count_q) &&
        $stable(bit_cnt_q) && $stable(rem) && $stable(o_rdata) && $stable(o_irq))
        else $error("state moved with clock enable low");
endmodule // pcg_top
`default_nettype wire

// [hdl/pcg_cfg.svh]
// Register offsets, field positions, reset values and sizes of the CRC generator
`ifndef PCG_CFG_SVH
`define PCG_CFG_SVH

// ==========================================
// Register word addresses
`define PCG_ADDR_W 2
`define PCG_ADDR_CTRL 2'h0
`define PCG_ADDR_TAP 2'h1
`define PCG_ADDR_DATA 2'h2

// ==========================================
// Control register fields
`define PCG_CTRL_IDLE 13
`define PCG_CTRL_CNT_LSB 8
`define PCG_CTRL_FULL 7
`define PCG_CTRL_EMPTY 6
`define PCG_CTRL_GO 4
`define PCG_CTRL_PLEN_LSB 0

// ==========================================
// Reset values and FIFO sizes
`define PCG_PLEN_RST 4'h0
`define PCG_TAP_RST 15'h0000
`define PCG_PLEN_SPLIT 4'h7
`define PCG_DEPTH_LONG 5'h08
`define PCG_DEPTH_SHORT 5'h10
`define PCG_FIFO_ENTRIES 16

`endif

// [hdl/pcg_pkg.sv]
// Types shared by the CRC generator modules
package pcg_pkg;
    typedef logic [15:0] pcg_word_t;
    typedef logic [4:0] pcg_count_t;
    typedef enum logic {
        SH_OFF,
        SH_RUN
    } pcg_shift_t;
endpackage

// [hdl/pcg_fifo.sv]
// Data word store of the CRC generator, sixteen entries
`timescale 1ns/1ns
`default_nettype none
`include "pcg_cfg.svh"
module pcg_fifo import pcg_pkg::*; (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_push,
    input wire logic i_pop,
    input wire logic i_flush,
    input wire pcg_word_t i_wdata,
    output pcg_word_t o_head
);
    // ==========================================
    // Storage and pointers
    pcg_word_t mem [`PCG_FIFO_ENTRIES];
    logic [3:0] wr_ptr_q;
    logic [3:0] rd_ptr_q;

    assign o_head = mem[rd_ptr_q];

    // Flush drops everything queued, pending push included
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr_q <= 4'h0;
            rd_ptr_q <= 4'h0;
        end else if (i_flush) begin
            wr_ptr_q <= 4'h0;
            rd_ptr_q <= 4'h0;
        end else begin
            if (i_push) wr_ptr_q <= wr_ptr_q + 4'h1;
            if (i_pop) rd_ptr_q <= rd_ptr_q + 4'h1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_push && !i_flush) mem[wr_ptr_q] <= i_wdata;
    end
endmodule // pcg_fifo
`default_nettype wire

// [hdl/pcg_engine.sv]
// Serial CRC remainder register with programmable length and taps
`timescale 1ns/1ns
`default_nettype none
`include "pcg_cfg.svh"
module pcg_engine import pcg_pkg::*; (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_shift,
    input wire logic i_clear,
    input wire logic i_bit,
    input wire logic [3:0] i_plen,
    input wire logic [15:1] i_taps,
    output pcg_word_t o_rem
);
    pcg_word_t rem_q;
    pcg_word_t rem_d;
    logic fb;

    // ==========================================
    // Feedback from the top stage of the programmed length
    assign fb = i_bit ^ rem_q[i_plen];
    assign rem_d[0] = fb;
    genvar gi;
    generate
        for (gi = 1; gi < 16; gi++) begin : g_stage
            // Stages above the length stay cleared
            assign rem_d[gi] = (4'(gi) <= i_plen) ?
                (rem_q[gi-1] ^ (fb & i_taps[gi])) : 1'b0;
        end
    endgenerate

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) rem_q <= 16'h0000;
        else if (i_clear) rem_q <= 16'h0000;
        else if (i_shift) rem_q <= rem_d;
    end

    assign o_rem = rem_q;
endmodule // pcg_engine
`default_nettype wire

// [bench/pcg_top_tb.sv]
// Self-checking testbench of the programmable CRC generator
`timescale 1ns/1ns
`default_nettype none
`include "pcg_cfg.svh"
module pcg_top_tb import pcg_pkg::*;;
    // ==========================================
    // Stimulus and observed signals
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic idle_mode = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [15:0] wdata = 16'h0000;
    logic [1:0] byte_en = 2'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic irq;
    logic full;
    logic empty;
    int errors = 0;
    int samples_checked = 0;
    int irq_cnt = 0;
    logic [15:0] rv;

    pcg_top DUT (.i_core_clk(clk), .i_rst_n(rst_n), .i_clk_en(clk_en), .i_idle_mode(idle_mode),
        .i_addr(addr), .i_wdata(wdata), .i_byte_en(byte_en), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .o_irq(irq), .o_fifo_full_flag(full), .o_fifo_empty_flag(empty));

    initial begin
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        if (irq === 1'b1) begin
            irq_cnt <= irq_cnt + 1;
        end
    end

    // ==========================================
    // Shared tasks
    task automatic complete_run;
        if (errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic bus_wr(input logic [1:0] a, input logic [15:0] d, input logic [1:0] be);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        byte_en <= be;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic bus_rd(input logic [1:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic check_count(input logic [4:0] exp);
        bus_rd(`PCG_ADDR_CTRL, rv);
        check({11'h000, rv[12:8]}, {11'h000, exp}, "word count");
    endtask

    // Counting starts just after the last edge the caller waited on
    task automatic wait_irq(input int exp_cycles);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 400) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 400) begin
            errors++;
            $display("BAD %0t interrupt never came", $time);
            complete_run();
        end
        check(16'(n), 16'(exp_cycles), "cycles to interrupt");
        @(posedge clk);
        #1;
        check({15'h0000, irq}, 16'h0000, "interrupt is one pulse");
        check({14'h0000, full, empty}, 16'h0001, "flags after drain");
    endtask

    // Remainder seeded by the caller, MSb first, top term implied by length
    function automatic pcg_word_t crc_model(input pcg_word_t r, input pcg_word_t w,
            input int plen, input pcg_word_t taps);
        pcg_word_t mask;
        logic fb;
        mask = pcg_word_t'((17'h00001 << (plen + 1)) - 17'h00001);
        for (int i = plen; i >= 0; i--) begin
            fb = r[plen] ^ w[i];
            r = (r << 1) & mask;
            if (fb) begin
                r = (r ^ {taps[15:1], 1'b1}) & mask;
            end
        end
        return r;
    endfunction

    // ==========================================
    // Scenarios
    task automatic scn_reset_and_taps;
        bus_rd(`PCG_ADDR_CTRL, rv);
        check(rv, 16'h0040, "control after reset");
        check({14'h0000, full, empty}, 16'h0001, "flag pins after reset");
        bus_wr(`PCG_ADDR_TAP, 16'hFFFF, 2'h3);
        bus_rd(`PCG_ADDR_TAP, rv);
        check(rv, 16'hFFFE, "tap field width");
        @(posedge clk);
        #1;
        check(rdata, 16'h0000, "read data lasts one cycle");
        bus_rd(2'h3, rv);
        check(rv, 16'h0000, "unmapped read");
    endtask

    // Two sixteen-bit words, second sent as two bytes; go cleared at once
    task automatic scn_crc16;
        pcg_word_t exp;
        bus_wr(`PCG_ADDR_CTRL, 16'h000F, 2'h3);
        bus_wr(`PCG_ADDR_TAP, 16'h1020, 2'h3);
        bus_wr(`PCG_ADDR_DATA, 16'h1234, 2'h3);
        bus_wr(`PCG_ADDR_DATA, 16'h0056, 2'h1);
        check_count(5'h01);
        bus_wr(`PCG_ADDR_DATA, 16'hAB00, 2'h2);
        repeat (5) @(posedge clk);
        check_count(5'h02);
        bus_wr(`PCG_ADDR_CTRL, 16'h001F, 2'h3);
        bus_wr(`PCG_ADDR_CTRL, 16'h000F, 2'h3);
        // Go was taken two edges before the wait starts
        wait_irq(2 * 16 - 2);
        exp = crc_model(crc_model(16'h0000, 16'h1234, 15, 16'h1020), 16'hAB56, 15, 16'h1020);
        bus_rd(`PCG_ADDR_DATA, rv);
        check(rv, exp, "sixteen bit remainder");
    endtask

    // Fill to depth, then one word more rolls the count over silently
    task automatic scn_fill_rollover(input logic [3:0] plen);
        int depth;
        int irq_before;
        depth = (plen > 4'h7) ? 8 : 16;
        bus_wr(`PCG_ADDR_CTRL, {12'h000, plen}, 2'h3);
        for (int i = 0; i < depth; i++) begin
            bus_wr(`PCG_ADDR_DATA, 16'(i), 2'h3);
        end
        check_count(5'(depth));
        check({15'h0000, full}, 16'h0001, "full flag at depth");
        irq_before = irq_cnt;
        bus_wr(`PCG_ADDR_DATA, 16'h00FF, 2'h3);
        check_count(5'h00);
        check({14'h0000, full, empty}, 16'h0001, "flags after rollover");
        check(16'(irq_cnt - irq_before), 16'h0000, "no interrupt on rollover");
    endtask

    // Idle stop holds the shifter until idle mode ends
    task automatic scn_idle_stop;
        bus_wr(`PCG_ADDR_CTRL, 16'h2003, 2'h3);
        bus_wr(`PCG_ADDR_TAP, 16'h0006, 2'h3);
        @(posedge clk);
        idle_mode <= 1'b1;
        bus_wr(`PCG_ADDR_DATA, 16'h00A5, 2'h1);
        bus_wr(`PCG_ADDR_CTRL, 16'h2013, 2'h3);
        repeat (10) @(posedge clk);
        check_count(5'h01);
        @(posedge clk);
        idle_mode <= 1'b0;
        wait_irq(4);
        bus_rd(`PCG_ADDR_DATA, rv);
        check(rv, crc_model(16'h0000, 16'h00A5, 3, 16'h0006), "four bit remainder");
        bus_wr(`PCG_ADDR_CTRL, 16'h0000, 2'h3);
    endtask

    // Preloaded stream refilled while running, clock enable frozen mid-word
    task automatic scn_stream_freeze;
        int irq_before;
        pcg_word_t exp;
        bus_wr(`PCG_ADDR_CTRL, 16'h0003, 2'h3);
        bus_wr(`PCG_ADDR_TAP, 16'h0006, 2'h3);
        bus_wr(`PCG_ADDR_DATA, 16'h000A, 2'h1);
        bus_wr(`PCG_ADDR_DATA, 16'h0003, 2'h1);
        check_count(5'h02);
        bus_wr(`PCG_ADDR_CTRL, 16'h0013, 2'h3);
        bus_wr(`PCG_ADDR_DATA, 16'h0006, 2'h1);
        @(posedge clk);
        clk_en <= 1'b0;
        irq_before = irq_cnt;
        repeat (20) @(posedge clk);
        check(16'(irq_cnt - irq_before), 16'h0000, "no interrupt while frozen");
        clk_en <= 1'b1;
        // Three words of four bits, three bits shifted before the freeze
        wait_irq(3 * 4 - 3);
        exp = crc_model(crc_model(crc_model(16'h0000, 16'h000A, 3, 16'h0006),
            16'h0003, 3, 16'h0006), 16'h0006, 3, 16'h0006);
        bus_rd(`PCG_ADDR_DATA, rv);
        check(rv, exp, "remainder across freeze");
        bus_wr(`PCG_ADDR_CTRL, 16'h0000, 2'h3);
    endtask

    // Reset in mid-run empties the queue, clears the full flag and sets the empty flag
    task automatic scn_mid_reset;
        bus_wr(`PCG_ADDR_DATA, 16'h0011, 2'h1);
        bus_wr(`PCG_ADDR_DATA, 16'h0022, 2'h1);
        check_count(5'h02);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        check({14'h0000, full, empty}, 16'h0001, "flag pins in reset");
        rst_n <= 1'b1;
        bus_rd(`PCG_ADDR_CTRL, rv);
        check(rv, 16'h0040, "control after mid-run reset");
    endtask

    // ==========================================
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        scn_reset_and_taps();
        scn_crc16();
        scn_fill_rollover(4'h7);
        scn_fill_rollover(4'h8);
        scn_idle_stop();
        scn_stream_freeze();
        scn_mid_reset();
        complete_run();
    end
endmodule // pcg_top_tb
`default_nettype wire
